//--- rtl/drt_pkg.sv
// constants and types for the reset delay timer
// Functional notes
// - any reset yields a nominal 18 ms delay, independent of main oscillator mode.
// - the timer runs on the dedicated internal RC oscillator, never the main clock.
// - processor reset stays asserted while the timer is active.
// - counting starts once master clear input is high; reset held about 18 ms after.
// - a watchdog time-out, also one waking from sleep, restarts the full delay.
package drt_pkg;

	// nominal delay in microseconds (18 ms) and oscillator rate in MHz
	localparam int DRT_DELAY_US = 18000;
	localparam int DRT_CLK_MHZ = 125;
	localparam int DRT_DELAY_CYCLES = DRT_DELAY_US * DRT_CLK_MHZ;

	localparam int DRT_CNT_W = 22;
	localparam logic [21:0] DRT_CNT_ZERO = 22'h000000;
	localparam logic [21:0] DRT_CNT_ONE = 22'h000001;

	typedef enum logic [2:0] {
		DRT_ST_HOLD = 3'h1,
		DRT_ST_COUNT = 3'h2,
		DRT_ST_RUN = 3'h4
	} drt_state_e;

	typedef enum logic [1:0] {
		DRT_CAUSE_POR = 2'h0,
		DRT_CAUSE_MASTER_CLEAR = 2'h1,
		DRT_CAUSE_WATCHDOG = 2'h2,
		DRT_CAUSE_WAKE = 2'h3
	} drt_cause_e;

	// reset sources, all synchronous to clk_sys
	typedef struct packed {
		logic master_clear_input;
		logic watchdog_timeout;
		logic sleep_active;
	} drt_src_s;

	typedef struct packed {
		logic timer_active;
		logic sleep_wake;
		drt_cause_e cause;
	} drt_status_s;

	localparam drt_status_s DRT_STATUS_RST = '{
		timer_active: 1'b1,
		sleep_wake: 1'b0,
		cause: DRT_CAUSE_POR
	};

endpackage

//--- rtl/drt_delay_counter.sv
// cycle counter that flags the last cycle of the reset delay
`timescale 1ns/1ns
`default_nettype none
module drt_delay_counter (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// control
	input wire logic clear,
	input wire logic enable,
	input wire logic [21:0] terminal,
	// status
	output logic last
);
	import drt_pkg::*;

	logic [21:0] count;
	wire logic [21:0] last_value;
	wire logic [21:0] count_inc;

	assign last_value = terminal - DRT_CNT_ONE;
	assign count_inc = count + DRT_CNT_ONE;
	assign last = enable && (count == last_value);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			count <= DRT_CNT_ZERO;
		end else if (clear) begin
			count <= DRT_CNT_ZERO;
		end else if (enable) begin
			count <= count_inc;
		end
	end
endmodule // drt_delay_counter
`default_nettype wire

//--- rtl/drt_reset_delay_timer.sv
// reset delay timer: holds the processor in reset after any reset source
`timescale 1ns/1ns
`default_nettype none
module drt_reset_delay_timer #(
	parameter int DELAY_CYCLES = drt_pkg::DRT_DELAY_CYCLES
) (
	// internal RC oscillator clock and power-on reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// reset sources
	input wire drt_pkg::drt_src_s src,
	// processor reset hold and status
	output logic cpu_reset_hold,
	output drt_pkg::drt_status_s status
);
	import drt_pkg::*;

	// clk_sys is the dedicated RC oscillator, so no main oscillator mode
	// can change the delay
	localparam logic [21:0] TERMINAL = DRT_CNT_W'(DELAY_CYCLES);

	drt_state_e state;
	drt_state_e next_state;
	drt_status_s next_status;

	wire logic master_clear_low;
	wire logic watchdog_hit;
	wire logic watchdog_restart;
	wire logic count_last;
	wire logic cnt_clear;
	wire logic cnt_enable;
	wire logic master_clear_event;

	assign master_clear_low = !src.master_clear_input;
	// a time-out while already held by master clear changes nothing
	assign watchdog_hit = src.watchdog_timeout && !master_clear_low;
	assign watchdog_restart = watchdog_hit
		&& (state != DRT_ST_HOLD);
	assign master_clear_event = master_clear_low && (state != DRT_ST_HOLD);

	// counter sits at zero outside COUNT, and is zeroed on a restart
	assign cnt_clear = (state != DRT_ST_COUNT)
		|| watchdog_restart;
	assign cnt_enable = (state == DRT_ST_COUNT) && !watchdog_restart;

	drt_delay_counter u_counter (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.clear(cnt_clear),
		.enable(cnt_enable),
		.terminal(TERMINAL),
		.last(count_last)
	);

	// master clear low wins over everything; brown-out relies on it
	always_comb begin
		next_state = state;
		case (state)
			DRT_ST_HOLD: begin
				if (!master_clear_low) begin
					next_state = DRT_ST_COUNT;
				end
			end
			DRT_ST_COUNT: begin
				if (master_clear_low) begin
					next_state = DRT_ST_HOLD;
				end else if (count_last) begin
					next_state = DRT_ST_RUN;
				end
			end
			DRT_ST_RUN: begin
				if (master_clear_low) begin
					next_state = DRT_ST_HOLD;
				end else if (watchdog_hit) begin
					next_state = DRT_ST_COUNT;
				end
			end
			default: begin
				next_state = DRT_ST_HOLD;
			end
		endcase
	end

	// cause is kept after release so firmware-side logic can see it
	always_comb begin
		next_status = status;
		next_status.timer_active = (next_state != DRT_ST_RUN);
		if (master_clear_event) begin
			next_status.cause = DRT_CAUSE_MASTER_CLEAR;
			next_status.sleep_wake = 1'b0;
		end else if (watchdog_restart) begin
			next_status.cause = src.sleep_active ? DRT_CAUSE_WAKE
				: DRT_CAUSE_WATCHDOG;
			next_status.sleep_wake = src.sleep_active;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= DRT_ST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// hold is registered from next_state so it drops on the very edge
	// that leaves COUNT, with no extra cycle of latency
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cpu_reset_hold <= 1'b1;
		end else begin
			cpu_reset_hold <= (next_state != DRT_ST_RUN);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			status <= DRT_STATUS_RST;
		end else begin
			status <= next_status;
		end
	end
endmodule // drt_reset_delay_timer
`default_nettype wire

//--- verif/drt_partner.sv
// master clear supervisor model
`timescale 1ns/1ns
`default_nettype none
module drt_partner (
	input wire logic clk_sys,
	input wire logic brownout,
	output var logic master_clear_input = 1'b0
);
	int n = 0;
	// released only once the supply has settled
	always @(posedge clk_sys) begin
		n <= brownout ? 0 : n + 1;
		master_clear_input <= !brownout && n > 2;
	end
endmodule // drt_partner
`default_nettype wire

//--- verif/drt_checker.sv
// port checker of the reset delay timer
`timescale 1ns/1ns
`default_nettype none
module drt_checker #(parameter int DELAY_CYCLES = 4) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire drt_pkg::drt_src_s src,
	input wire logic cpu_reset_hold,
	input wire drt_pkg::drt_status_s status
);
	import drt_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	wire logic hi = src.master_clear_input;
	wire logic wd = hi && src.watchdog_timeout;
	int cnt;
	// -1 while idle, saturates at the delay
	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
			cnt <= -1;
		else
			cnt <= !hi ? -1 : wd ? 0 : cnt + 32'(cnt < DELAY_CYCLES);
	property p_len; cpu_reset_hold == (cnt != DELAY_CYCLES); endproperty
	a_len: assert property (p_len)
		else $error("len");
	property p_act; status.timer_active == cpu_reset_hold; endproperty
	a_act: assert property (p_act)
		else $error("act");
	property p_low; !hi |=> cpu_reset_hold; endproperty
	a_low: assert property (p_low)
		else $error("low");
	property p_wd; wd && $past(hi) |=> cpu_reset_hold && status.cause[1];
	endproperty
	a_wd: assert property (p_wd)
		else $error("wd");
	property p_wake;
		wd && $past(hi) |=> status.sleep_wake == $past(src.sleep_active);
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake");
	property p_mc; $fell(hi) && !cpu_reset_hold |=> status.cause == 2'h1;
	endproperty
	a_mc: assert property (p_mc)
		else $error("cause");
	c_fall: cover property ($fell(cpu_reset_hold));
	c_wake: cover property (wd && src.sleep_active);
	c_bo: cover property ($fell(hi) && !cpu_reset_hold);
endmodule // drt_checker
bind drt_reset_delay_timer drt_checker #(.DELAY_CYCLES(DELAY_CYCLES)) u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .src(src),
	.cpu_reset_hold(cpu_reset_hold), .status(status));
`default_nettype wire

//--- verif/device_reset_delay_timer_tb.sv
// self-checking bench of the reset delay timer
`timescale 1ns/1ns
`default_nettype none
module device_reset_delay_timer_tb;
	import drt_pkg::*;
	localparam int D = 6;
	logic clk_sys = 0, rst_b = 0, bo = 1, wd = 0, slp = 0, prev = 1;
	logic cpu_reset_hold;
	drt_status_s status;
	wire logic mc;
	int cyc = 0, n_errors = 0, compares = 0;
	logic [35:0] q[$];
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	drt_partner u_sup (.clk_sys(clk_sys), .brownout(bo),
		.master_clear_input(mc));
	drt_reset_delay_timer #(.DELAY_CYCLES(D)) dut (.clk_sys(clk_sys),
		.rst_b(rst_b), .src('{mc, wd, slp}),
		.cpu_reset_hold(cpu_reset_hold), .status(status));
	task cmp(logic [35:0] got, logic [35:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask
	task stop_test;
		if (n_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// release due D edges after the next one
	task note(logic [3:0] st);
		q.push_back({cyc + 1 + D, st});
	endtask
	task pulse(logic s);
		slp = s;
		wd = 1;
		if (q.size() && q[$][35:4] > cyc)
			void'(q.pop_back());
		note({1'b0, s, 1'b1, s});
		@(negedge clk_sys) wd = 0;
	endtask
	always @(negedge clk_sys) begin
		if (prev === 1 && cpu_reset_hold === 0)
			cmp({cyc, status}, q.size() ? q.pop_front() : '1);
		prev = cpu_reset_hold;
	end
	initial begin
		void'($urandom(32'hcbe4));
		repeat (5) @(negedge clk_sys);
		rst_b = 1;
		bo = 0;
		@(posedge mc);
		@(negedge clk_sys) note({2'b0, DRT_CAUSE_POR});
		repeat (D + 2) @(negedge clk_sys);
		bo = 1;
		repeat (2) @(negedge clk_sys);
		wd = 1;
		@(negedge clk_sys) bo = 0;
		wd = 0;
		@(posedge mc);
		@(negedge clk_sys) note({2'b0, DRT_CAUSE_MASTER_CLEAR});
		repeat (D + 2) @(negedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			pulse(1'($urandom));
			if (i % 2) begin
				@(negedge clk_sys);
				pulse(1'($urandom));
			end
			repeat (D + $urandom % 3) @(negedge clk_sys);
		end
		repeat (2) @(negedge clk_sys);
		cmp(36'(q.size()), 36'h0);
		stop_test;
	end
	initial begin
		#20000;
		n_errors++;
		stop_test;
	end
endmodule // device_reset_delay_timer_tb
`default_nettype wire
